// ### hw/spfa_loop_ctrl.sv
// One loop's powerdown state machine and charge-pump control
`timescale 1ns/1ps
`default_nettype none
module spfa_loop_ctrl
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_sleep,
   input wire logic i_pump_hiz_bit,
   input wire logic i_pump_idle,
   input wire logic i_fast,
   output spfa_pkg::spfa_loop_stat_type o_stat
);
   import spfa_pkg::*;
   typedef enum logic [1:0]
   {
      ST_ACTIVE = 2'b00,
      ST_WAIT_IDLE = 2'b01,
      ST_ASLEEP = 2'b10
   } spfa_pd_state_type;
   spfa_pd_state_type state;
   spfa_pd_state_type next_state;
   logic gain_now;

   // ==========================================
   // Powerdown sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         ST_ACTIVE:
            if (i_sleep)
               next_state = i_pump_hiz_bit ? ST_ASLEEP : ST_WAIT_IDLE;
         ST_WAIT_IDLE:
            if (!i_sleep)
               next_state = ST_ACTIVE;
            else if (i_pump_idle)
               next_state = ST_ASLEEP;
         ST_ASLEEP:
            if (!i_sleep)
               next_state = ST_ACTIVE;
         default:
            next_state = ST_ACTIVE;
      endcase
   end

   // Gain changes only while the pump is idle, so no half-step lands on the filter
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= ST_ACTIVE;
         gain_now <= 1'b0;
         o_stat <= '0;
      end
      else
      begin
         state <= next_state;
         if (i_pump_idle)
            gain_now <= i_fast;
         o_stat.asleep <= (next_state == ST_ASLEEP);
         o_stat.dividers_load <= (next_state == ST_ASLEEP);
         o_stat.input_hiz <= (next_state == ST_ASLEEP);
         o_stat.pump_hiz <= i_pump_hiz_bit | (next_state == ST_ASLEEP);
         o_stat.pump_gain <= (i_pump_idle ? i_fast : gain_now) ?
                             3'(PUMP_GAIN_RATIO) : 3'h1;
      end
   end
endmodule // spfa_loop_ctrl
`default_nettype wire

// ### hw/spfa_serial_rx.sv
// Three-wire serial receiver: samples pins, shifts MSB first, latches on strobe
`timescale 1ns/1ps
`default_nettype none
module spfa_serial_rx
#(
   parameter int WIDTH = spfa_pkg::WORD_BITS
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_sdata,
   input wire logic i_sclk,
   input wire logic i_latch_strobe,
   output logic [WIDTH-1:0] o_word,
   output logic o_word_valid
);
   import spfa_pkg::*;
   // ==========================================
   // Pin synchronisers
   logic [SYNC_STAGES-1:0] data_sync;
   logic [SYNC_STAGES-1:0] clk_sync;
   logic [SYNC_STAGES-1:0] strobe_sync;
   logic clk_prev;
   logic strobe_prev;
   logic [WIDTH-1:0] shift;
   wire clk_rise = clk_sync[1] & ~clk_prev;
   wire strobe_rise = strobe_sync[1] & ~strobe_prev;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         data_sync <= 2'h0;
         clk_sync <= 2'h0;
         strobe_sync <= 2'h0;
         clk_prev <= 1'b0;
         strobe_prev <= 1'b0;
      end
      else
      begin
         data_sync <= {data_sync[0], i_sdata};
         clk_sync <= {clk_sync[0], i_sclk};
         strobe_sync <= {strobe_sync[0], i_latch_strobe};
         clk_prev <= clk_sync[1];
         strobe_prev <= strobe_sync[1];
      end
   end

   // ==========================================
   // Shift and latch
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         shift <= '0;
         o_word <= '0;
         o_word_valid <= 1'b0;
      end
      else
      begin
         if (clk_rise)
            shift <= {shift[WIDTH-2:0], data_sync[1]};
         o_word_valid <= strobe_rise;
         if (strobe_rise)
            o_word <= shift;
      end
   end
endmodule // spfa_serial_rx
`default_nettype wire

// ### hw/spfa_top.sv
// Dual-loop synthesizer control: serial programming, powerdown and fast acquisition
// Overview of operation
// - Sleep bit high with pump hi-z bit low selects synchronous powerdown.
// - Sleep bit high with pump hi-z bit high selects asynchronous powerdown.
// - Synchronous powerdown waits until the charge pump is idle.
// - Asynchronous powerdown takes effect right after the latch strobe.
// - A sleeping loop holds dividers in load and its RF input hi-z.
// - Reference oscillator runs unless both loops' sleep bits are set.
// - Serial register keeps shifting and latching during any powerdown.
// - Latching a low sleep bit wakes the loop immediately.
// - Hi-z bit alone keeps loop active with pump output hi-z.
// - Data bits are captured on serial clock rising edges.
// - Words are sent and shifted most significant bit first.
// - Fast acquisition gives four times normal pump current.
// - Fast acquisition pulls damping resistor node low via open drain.
// - Return to standard mode follows the charge pump output; only the pump gain waits for pump idle, the open drain is released at once.
// - Prescaler and sleep bits are the top two feedback bits.
// - Fast acquisition only with fast-acquisition pin state and RF gain high.
`timescale 1ns/1ps
`default_nettype none
module spfa_top
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_sdata,
   input wire logic i_sclk,
   input wire logic i_latch_strobe,
   input wire logic i_if_pump_idle,
   input wire logic i_rf_pump_idle,
   output spfa_pkg::spfa_ref_type o_if_ref,
   output spfa_pkg::spfa_ref_type o_rf_ref,
   output spfa_pkg::spfa_fb_type o_if_fb,
   output spfa_pkg::spfa_fb_type o_rf_fb,
   output spfa_pkg::spfa_loop_stat_type o_if_stat,
   output spfa_pkg::spfa_loop_stat_type o_rf_stat,
   output logic o_osc_enable,
   output logic o_multifunction_output,
   output logic o_multifunction_output_oe
);
   import spfa_pkg::*;

   // ==========================================
   // Reset release
   logic [1:0] rst_sync;
   wire rst_n = rst_sync[1];
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   // ==========================================
   // Pump idle inputs come from the analog side, so synchronise them
   logic [1:0] if_idle_sync;
   logic [1:0] rf_idle_sync;
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         if_idle_sync <= 2'h0;
         rf_idle_sync <= 2'h0;
      end
      else
      begin
         if_idle_sync <= {if_idle_sync[0], i_if_pump_idle};
         rf_idle_sync <= {rf_idle_sync[0], i_rf_pump_idle};
      end
   end

   // ==========================================
   // Serial receiver; never gated by powerdown
   logic [WORD_BITS-1:0] word;
   logic word_valid;
   spfa_serial_rx #(.WIDTH(WORD_BITS)) u_rx
   (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_sdata(i_sdata),
      .i_sclk(i_sclk),
      .i_latch_strobe(i_latch_strobe),
      .o_word(word),
      .o_word_valid(word_valid)
   );

   // ==========================================
   // Word decode
   wire [1:0] sel = word[CTRL_LSB+1:CTRL_LSB];
   wire [WORD_BITS-DATA_LSB-1:0] payload = word[WORD_BITS-1:DATA_LSB];
   wire ld_if_ref = word_valid && sel == SEL_IF_REF;
   wire ld_rf_ref = word_valid && sel == SEL_RF_REF;
   wire ld_if_fb = word_valid && sel == SEL_IF_FB;
   wire ld_rf_fb = word_valid && sel == SEL_RF_FB;
   spfa_ref_type ref_in;
   spfa_fb_type fb_in;
   assign ref_in = spfa_ref_type'(payload);
   assign fb_in = spfa_fb_type'(payload);

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_if_ref <= '0;
         o_rf_ref <= '0;
         o_if_fb <= '0;
         o_rf_fb <= '0;
      end
      else
      begin
         if (ld_if_ref)
            o_if_ref <= ref_in;
         if (ld_rf_ref)
            o_rf_ref <= ref_in;
         if (ld_if_fb)
            o_if_fb <= fb_in;
         if (ld_rf_fb)
            o_rf_fb <= fb_in;
      end
   end

   // ==========================================
   // Fast acquisition: both RF and IF lock/pin selects high except lock selects low
   wire fast_state = !o_rf_ref.lock_detect_select_bit && !o_if_ref.lock_detect_select_bit
                     && o_rf_ref.pin_function_select_bit && o_if_ref.pin_function_select_bit;
   wire rf_fast = fast_state && o_rf_ref.gain_high;

   // ==========================================
   // Independent loop controllers
   spfa_loop_ctrl u_if_loop
   (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_sleep(o_if_fb.loop_sleep_bit),
      .i_pump_hiz_bit(o_if_ref.pump_hiz_bit),
      .i_pump_idle(if_idle_sync[1]),
      .i_fast(1'b0),
      .o_stat(o_if_stat)
   );
   spfa_loop_ctrl u_rf_loop
   (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_sleep(o_rf_fb.loop_sleep_bit),
      .i_pump_hiz_bit(o_rf_ref.pump_hiz_bit),
      .i_pump_idle(rf_idle_sync[1]),
      .i_fast(rf_fast),
      .o_stat(o_rf_stat)
   );

   // ==========================================
   // Oscillator and multifunction pin
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_osc_enable <= 1'b1;
         o_multifunction_output <= 1'b0;
         o_multifunction_output_oe <= 1'b0;
      end
      else
      begin
         o_osc_enable <= !(o_if_fb.loop_sleep_bit && o_rf_fb.loop_sleep_bit);
         o_multifunction_output <= 1'b0;
         // Open drain: drives low only while fast acquisition is on
         o_multifunction_output_oe <= rf_fast;
      end
   end
endmodule // spfa_top
`default_nettype wire

// ### inc/spfa_pkg.sv
// Shared constants and carrier types for the synthesizer powerdown and fast-acquisition control
`default_nettype none
package spfa_pkg;
   // Serial word: 22 bits, two control bits at the bottom, shifted in MSB first
   localparam int WORD_BITS = 22;
   localparam int CTRL_LSB = 0;
   localparam int DATA_LSB = 2;
   // Control codes (first-shifted control bit is the upper one of the pair)
   localparam logic [1:0] SEL_IF_REF = 2'h0;
   localparam logic [1:0] SEL_RF_REF = 2'h1;
   localparam logic [1:0] SEL_IF_FB = 2'h2;
   localparam logic [1:0] SEL_RF_FB = 2'h3;
   // Reference word field positions within the full word
   localparam int POS_PHASE_POL = 17;
   localparam int POS_GAIN = 18;
   localparam int POS_PUMP_HIZ = 19;
   localparam int POS_LOCK_SEL = 20;
   localparam int POS_PIN_FUNC = 21;
   // Feedback word field positions (upper two bits)
   localparam int POS_PRESCALER = 20;
   localparam int POS_SLEEP = 21;
   localparam int REF_CNT_W = 15;
   localparam int FB_CNT_W = 18;
   // Reset values
   localparam logic [REF_CNT_W-1:0] RST_REF_CNT = 15'h0000;
   localparam logic [FB_CNT_W-1:0] RST_FB_CNT = 18'h00000;
   localparam int SYNC_STAGES = 2;
   // Charge-pump gain ratio in fast acquisition versus standard mode
   localparam int PUMP_GAIN_RATIO = 4;

   typedef struct packed
   {
      // Highest field first, so the struct lines up with the POS_ constants
      logic pin_function_select_bit;
      logic lock_detect_select_bit;
      logic pump_hiz_bit;
      logic gain_high;
      logic phase_pol;
      logic [REF_CNT_W-1:0] ref_count;
   } spfa_ref_type;

   typedef struct packed
   {
      logic loop_sleep_bit;
      logic prescaler_select_bit;
      logic [FB_CNT_W-1:0] fb_count;
   } spfa_fb_type;

   typedef struct packed
   {
      logic asleep;
      logic dividers_load;
      logic input_hiz;
      logic pump_hiz;
      logic [2:0] pump_gain;
   } spfa_loop_stat_type;
endpackage
`default_nettype wire

// ### test/spfa_host_model.sv
// Behavioural host driving the three serial pins
`timescale 1ns/1ps
`default_nettype none
module spfa_host_model
(
   output logic o_sdata,
   output logic o_sclk,
   output logic o_latch_strobe
);
   initial
   begin
      o_sdata = 1'b0;
      o_sclk = 1'b0;
      o_latch_strobe = 1'b0;
   end
   // Half is the clock half period in ns; larger values model a slow host
   task automatic send(input logic [21:0] w, input int half, input bit latch);
      for (int i = 21; i >= 0; i--)
      begin
         o_sdata = w[i];
         #(half / 2) o_sclk = 1'b1;
         #(half) o_sclk = 1'b0;
         #(half / 2);
      end
      // Released data line must not look like a held bit
      o_sdata = ~o_sdata;
      #(half) o_latch_strobe = latch;
      #(2 * half) o_latch_strobe = 1'b0;
      #(half);
   endtask
endmodule // spfa_host_model
`default_nettype wire

// ### test/spfa_top_properties.sv
// Port-level assertions for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module spfa_top_properties
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_rf_pump_idle,
   input wire spfa_pkg::spfa_ref_type o_if_ref,
   input wire spfa_pkg::spfa_ref_type o_rf_ref,
   input wire spfa_pkg::spfa_fb_type o_if_fb,
   input wire spfa_pkg::spfa_fb_type o_rf_fb,
   input wire spfa_pkg::spfa_loop_stat_type o_if_stat,
   input wire spfa_pkg::spfa_loop_stat_type o_rf_stat,
   input wire logic o_osc_enable,
   input wire logic o_multifunction_output,
   input wire logic o_multifunction_output_oe
);
   import spfa_pkg::*;
   // ==========
   // Helpers
   wire both_sleep = o_if_fb.loop_sleep_bit && o_rf_fb.loop_sleep_bit;
   wire fast_sel = !o_if_ref.lock_detect_select_bit && !o_rf_ref.lock_detect_select_bit
      && o_if_ref.pin_function_select_bit && o_rf_ref.pin_function_select_bit;
   wire boost = o_rf_stat.pump_gain == 3'(PUMP_GAIN_RATIO);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Idle passes two sync flops, so look a few cycles back
   sequence rf_idle_seen;
      $past(i_rf_pump_idle, 2) || $past(i_rf_pump_idle, 3) || $past(i_rf_pump_idle, 4);
   endsequence
   sequence if_async_latch;
      $rose(o_if_fb.loop_sleep_bit) && o_if_ref.pump_hiz_bit;
   endsequence
   // ==========
   // Properties
   a_osc_both_off: assert property (both_sleep |=> !o_osc_enable)
      else $error("oscillator left running");
   a_osc_kept_on: assert property (!both_sleep |=> o_osc_enable)
      else $error("oscillator stopped early");
   a_async_sleep: assert property (if_async_latch |=> o_if_stat.asleep)
      else $error("async powerdown late");
   a_sync_gated: assert property ($rose(o_rf_stat.asleep) && !o_rf_ref.pump_hiz_bit
      |-> rf_idle_seen)
      else $error("sync powerdown before pump idle");
   a_sleep_holds: assert property (o_rf_stat.asleep
      |-> o_rf_stat.dividers_load && o_rf_stat.input_hiz)
      else $error("sleeping loop not held");
   a_wake_now: assert property ($fell(o_if_fb.loop_sleep_bit) |=> !o_if_stat.asleep)
      else $error("loop wake late");
   a_hiz_active: assert property ((o_if_ref.pump_hiz_bit && !o_if_fb.loop_sleep_bit) [*2]
      |-> o_if_stat.pump_hiz && !o_if_stat.asleep)
      else $error("hi-z loop not active");
   a_boost_cause: assert property ($rose(boost)
      |-> $past(fast_sel && o_rf_ref.gain_high))
      else $error("boost without fast state");
   a_drain_low: assert property ($rose(o_multifunction_output_oe)
      |-> !o_multifunction_output && $past(fast_sel && o_rf_ref.gain_high))
      else $error("open drain misused");
   a_std_at_idle: assert property ($fell(boost) |-> rf_idle_seen)
      else $error("gain dropped off pump idle");
endmodule // spfa_top_properties
bind spfa_top spfa_top_properties u_spfa_top_properties (.i_mclk, .i_rst_n, .i_rf_pump_idle,
   .o_if_ref, .o_rf_ref, .o_if_fb, .o_rf_fb, .o_if_stat, .o_rf_stat, .o_osc_enable,
   .o_multifunction_output, .o_multifunction_output_oe);
`default_nettype wire

// ### test/spfa_top_tb_top.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module spfa_top_tb_top;
   import spfa_pkg::*;
   logic mclk, rst_n, if_idle, rf_idle, sdata, sclk, strobe, osc, mfo, mfo_oe;
   spfa_ref_type if_ref, rf_ref;
   spfa_fb_type if_fb, rf_fb;
   spfa_loop_stat_type if_st, rf_st;
   int err_count = 0;
   int compares = 0;
   logic [31:0] seed = 32'hB5DD60B7;
   spfa_top u_spfa_top (.i_mclk(mclk), .i_rst_n(rst_n), .i_sdata(sdata), .i_sclk(sclk),
      .i_latch_strobe(strobe), .i_if_pump_idle(if_idle), .i_rf_pump_idle(rf_idle),
      .o_if_ref(if_ref), .o_rf_ref(rf_ref), .o_if_fb(if_fb), .o_rf_fb(rf_fb),
      .o_if_stat(if_st), .o_rf_stat(rf_st), .o_osc_enable(osc),
      .o_multifunction_output(mfo), .o_multifunction_output_oe(mfo_oe));
   spfa_host_model u_spfa_host_model (.o_sdata(sdata), .o_sclk(sclk), .o_latch_strobe(strobe));
   // ==========
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Mode bits m are pin select, lock select, pump hi-z, gain, polarity
   function automatic logic [21:0] rw(logic [1:0] c, logic [4:0] m, logic [14:0] n);
      return {m, n, c};
   endfunction
   function automatic logic [21:0] fw(logic [1:0] c, logic [1:0] sp, logic [17:0] n);
      return {sp, n, c};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tx(input logic [21:0] w);
      @(negedge mclk);
      u_spfa_host_model.send(w, 32, 1'b1);
      repeat (10) @(negedge mclk);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========
   // Clock, watchdog, tests
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial
   begin
      #300000;
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      logic [31:0] r;
      rst_n = 1'b0;
      if_idle = 1'b1;
      rf_idle = 1'b1;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      check(osc, 1);
      for (int k = 0; k < 6; k++)
      begin
         r = rnd();
         tx(rw(SEL_RF_REF, {2'h0, r[17:15]}, r[14:0]));
         tx(fw(SEL_IF_FB, {1'b0, r[18]}, r[31:14]));
         check(rf_ref.ref_count, r[14:0]);
         check(rf_ref.pump_hiz_bit, r[17]);
         check(rf_ref.gain_high, r[16]);
         check(rf_ref.phase_pol, r[15]);
         check(if_fb.fb_count, r[31:14]);
         check(if_fb.prescaler_select_bit, r[18]);
         check(if_ref.ref_count, 0);
      end
      $display("random words done");
      @(negedge mclk);
      u_spfa_host_model.send(rw(SEL_RF_REF, 5'h00, 15'h7FFF), 32, 1'b0);
      repeat (10) @(negedge mclk);
      check(rf_ref.ref_count, r[14:0]);
      @(negedge mclk);
      u_spfa_host_model.send(rw(SEL_RF_REF, 5'h00, 15'h0055), 96, 1'b1);
      repeat (10) @(negedge mclk);
      check(rf_ref.ref_count, 15'h0055);
      $display("latch gating done");
      tx(rw(SEL_IF_REF, 5'h04, 15'h0003));
      tx(fw(SEL_IF_FB, 2'h2, 18'h0));
      check(if_st.asleep, 1);
      check(if_st.dividers_load, 1);
      check(if_st.input_hiz, 1);
      check(rf_st.asleep, 0);
      check(osc, 1);
      rf_idle = 1'b0;
      tx(fw(SEL_RF_FB, 2'h2, 18'h0));
      check(rf_st.asleep, 0);
      tx(rw(SEL_IF_REF, 5'h04, 15'h1234));
      check(if_ref.ref_count, 15'h1234);
      rf_idle = 1'b1;
      repeat (8) @(negedge mclk);
      check(rf_st.asleep, 1);
      check(osc, 0);
      tx(fw(SEL_RF_FB, 2'h0, 18'h0));
      check(rf_st.asleep, 0);
      tx(fw(SEL_IF_FB, 2'h0, 18'h0));
      check(if_st.asleep, 0);
      check(if_st.pump_hiz, 1);
      $display("powerdown done");
      tx(rw(SEL_IF_REF, 5'h10, 15'h0));
      tx(rw(SEL_RF_REF, 5'h12, 15'h0));
      check(rf_st.pump_gain, PUMP_GAIN_RATIO);
      check({mfo_oe, mfo}, 2'h2);
      rf_idle = 1'b0;
      tx(rw(SEL_RF_REF, 5'h10, 15'h0));
      check(rf_st.pump_gain, PUMP_GAIN_RATIO);
      rf_idle = 1'b1;
      repeat (8) @(negedge mclk);
      check(rf_st.pump_gain, 1);
      check(mfo_oe, 0);
      tx(rw(SEL_RF_REF, 5'h02, 15'h0));
      check(rf_st.pump_gain, 1);
      $display("fast acquisition done");
      tx(fw(SEL_IF_FB, 2'h2, 18'h0));
      tx(fw(SEL_RF_FB, 2'h2, 18'h0));
      check(rf_fb.loop_sleep_bit, 1);
      check(rf_st.dividers_load, 1);
      check(osc, 0);
      rst_n = 1'b0;
      @(negedge mclk);
      check(osc, 1);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      check(rf_fb.loop_sleep_bit, 0);
      check(rf_st.input_hiz, 0);
      check(osc, 1);
      $display("reset done");
      tally_and_finish();
   end
endmodule // spfa_top_tb_top
`default_nettype wire
